/* hw/sfm_standby_mode_regs.sv */
// Notes on behaviour
// - In standby one or two, or with the output enable pin low, the polarity register drives the outputs.
// - Polarity bits 0 to 12 give the levels of vertical channels 1 to 13, bit 0 for channel 1.
// - Polarity bits 13 to 20 give the levels of sensor gates 1 to 8 in ascending order.
// - Polarity bit 21 gives the substrate clock level in standby one or two or with the output enable pin low.
// - A frame whose top two address bits are 10 writes the mode register, the other ten address bits being data 37 to 28.
// - Mode bits 37 to 35 give the number of fields in the sequence, seven at most.
// - The mode register holds seven 5-bit selectors, bits 4 to 0 for position one and upward.
// - A written mode value takes effect only at the next vertical sync.
// - Toggle position tables power up undefined and are never assumed to hold a value.
`timescale 1ns/10ps
`default_nettype none

module sfm_standby_mode_regs (
  input  wire logic                           ref_clk,              // 250 MHz clock
  input  wire logic                           reset,                // Sync reset, active high
  input  wire logic                           ser_load_n,           // Serial frame select, active low
  input  wire logic                           ser_clk,              // Serial bit clock
  input  wire logic                           ser_data,             // Serial data in
  input  wire logic [1:0]                     power_state,          // 0 run, 1..3 standby
  input  wire logic                           output_enable_pin,    // Low forces static levels
  input  wire logic                           vertical_sync,        // Vertical sync level
  input  wire logic [sfm_pkg::NUM_VOUT-1:0]   vtg_vertical,         // Timing generator vertical
  input  wire logic [sfm_pkg::NUM_SG-1:0]     vtg_sensor_gate,      // Timing generator sensor gates
  input  wire logic                           vtg_substrate,        // Timing generator substrate clk
  output logic [sfm_pkg::NUM_VOUT-1:0]        vertical_out,         // Vertical channels 1..13
  output logic [sfm_pkg::NUM_SG-1:0]          sensor_gate_out,      // Sensor gates 1..8
  output logic                                substrate_clock_out,  // Substrate clock
  output logic [sfm_pkg::STBY_W-1:0]          standby_levels,       // Polarity register readback
  output logic [sfm_pkg::MODE_W-1:0]          mode_pending,         // Written mode value
  output logic [sfm_pkg::MODE_W-1:0]          mode_active,          // Mode value in use
  output logic [sfm_pkg::POS_W-1:0]           field_position,       // Current position 1..7
  output logic [sfm_pkg::SEL_W-1:0]           field_select          // Field definition for position
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic                            wr_stb;
  logic [sfm_pkg::ADDR_W-1:0]      wr_addr;
  logic [sfm_pkg::DATA_W-1:0]      wr_data;
  logic [sfm_pkg::STBY_W-1:0]      stby12_ff;
  logic [sfm_pkg::MODE_W-1:0]      mode_pend_ff;
  logic [sfm_pkg::MODE_W-1:0]      mode_act_ff;
  logic [sfm_pkg::POS_W-1:0]       pos_ff;
  logic [sfm_pkg::POS_W-1:0]       nxt_pos;
  logic [sfm_pkg::POS_W-1:0]       nxt_count;
  logic [sfm_pkg::NUM_VOUT-1:0]    vout_ff;
  logic [sfm_pkg::NUM_SG-1:0]      sg_ff;
  logic                            subck_ff;
  logic                            vsync_prev_ff;
  logic                            vsync_rise;
  logic                            force_static;
  logic                            mode_wr;
  logic                            stby_wr;
  logic [sfm_pkg::SEL_W-1:0]       sel_ff;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [sfm_pkg::SEL_W-1:0] pick_sel(
    input logic [sfm_pkg::MODE_W-1:0] mode,
    input logic [sfm_pkg::POS_W-1:0]  pos
  );
    logic [sfm_pkg::POS_W-1:0] idx;
    idx = (pos == 3'h0) ? 3'h0 : pos - 3'h1;
    pick_sel = mode[idx*sfm_pkg::SEL_W +: sfm_pkg::SEL_W];
  endfunction : pick_sel

  function automatic logic [sfm_pkg::POS_W-1:0] field_count(
    input logic [sfm_pkg::MODE_W-1:0] mode
  );
    field_count = mode[sfm_pkg::MODE_W-1:sfm_pkg::COUNT_LSB];
  endfunction : field_count

  function automatic logic is_stby_addr(
    input logic [sfm_pkg::ADDR_W-1:0] addr
  );
    is_stby_addr = (addr == sfm_pkg::STBY12_ADDR);
  endfunction : is_stby_addr

  function automatic logic is_mode_addr(
    input logic [sfm_pkg::ADDR_W-1:0] addr
  );
    is_mode_addr = (addr[sfm_pkg::MODE_TAG_HI:sfm_pkg::MODE_TAG_LO] == sfm_pkg::MODE_TAG);
  endfunction : is_mode_addr

  function automatic logic levels_forced(
    input logic [1:0] pstate,
    input logic       oe_pin
  );
    levels_forced = (pstate == 2'(sfm_pkg::SFM_STBY1)) ||
                    (pstate == 2'(sfm_pkg::SFM_STBY2)) ||
                    !oe_pin;
  endfunction : levels_forced

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  sfm_serial_rx u_rx (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .ser_load_n (ser_load_n),
    .ser_clk    (ser_clk),
    .ser_data   (ser_data),
    .wr_stb     (wr_stb),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data)
  );

  assign mode_wr = wr_stb && is_mode_addr(wr_addr);
  assign stby_wr = wr_stb && is_stby_addr(wr_addr);

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stby12_ff <= sfm_pkg::STBY_RESET;
    end else if (stby_wr) begin
      stby12_ff <= wr_data[sfm_pkg::STBY_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_pend_ff <= sfm_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_pend_ff <= {wr_addr[sfm_pkg::MODE_UP_HI:0], wr_data};
    end
  end

  // ------------------------------------------------------------
  // Vertical sync boundary
  // ------------------------------------------------------------
  assign vsync_rise = vertical_sync & ~vsync_prev_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vsync_prev_ff <= 1'b0;
    end else begin
      vsync_prev_ff <= vertical_sync;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_act_ff <= sfm_pkg::MODE_RESET;
    end else if (vsync_rise) begin
      mode_act_ff <= mode_pend_ff;
    end
  end

  // ------------------------------------------------------------
  // Field sequence position
  // ------------------------------------------------------------
  always_comb begin
    nxt_count = field_count(mode_pend_ff);
    nxt_pos   = pos_ff;
    if (vsync_rise) begin
      if ((nxt_count == 3'h0) || (pos_ff >= nxt_count)) begin
        nxt_pos = sfm_pkg::POS_FIRST;
      end else begin
        nxt_pos = pos_ff + 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pos_ff <= sfm_pkg::POS_FIRST;
    end else begin
      pos_ff <= nxt_pos;
    end
  end

  // ------------------------------------------------------------
  // Field selector, registered with the position
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_ff <= '0;
    end else if (vsync_rise) begin
      sel_ff <= pick_sel(mode_pend_ff, nxt_pos);
    end
  end

  // ------------------------------------------------------------
  // Output level selection
  // ------------------------------------------------------------
  // Toggle tables live upstream; their contents are never assumed here
  assign force_static = levels_forced(power_state, output_enable_pin);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vout_ff <= '0;
    end else if (force_static) begin
      vout_ff <= stby12_ff[sfm_pkg::VOUT_LSB +: sfm_pkg::NUM_VOUT];
    end else begin
      vout_ff <= vtg_vertical;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sg_ff <= '0;
    end else if (force_static) begin
      sg_ff <= stby12_ff[sfm_pkg::SG_LSB +: sfm_pkg::NUM_SG];
    end else begin
      sg_ff <= vtg_sensor_gate;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      subck_ff <= 1'b0;
    end else if (force_static) begin
      subck_ff <= stby12_ff[sfm_pkg::SUBCK_BIT];
    end else begin
      subck_ff <= vtg_substrate;
    end
  end

  assign vertical_out        = vout_ff;
  assign sensor_gate_out     = sg_ff;
  assign substrate_clock_out = subck_ff;
  assign standby_levels      = stby12_ff;
  assign mode_pending        = mode_pend_ff;
  assign mode_active         = mode_act_ff;
  assign field_position      = pos_ff;
  assign field_select        = sel_ff;

endmodule : sfm_standby_mode_regs

`default_nettype wire

/* hw/sfm_pkg.sv */
package sfm_pkg;

  // ------------------------------------------------------------
  // Serial frame layout
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned DATA_W     = 28;
  localparam int unsigned FRAME_BITS = ADDR_W + DATA_W;
  localparam int unsigned CNT_W      = 6;
  localparam logic [CNT_W-1:0] FRAME_CNT = 6'h28;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STBY12_ADDR = 12'h0F3;
  localparam logic [1:0]        MODE_TAG    = 2'h2;
  localparam int unsigned       MODE_TAG_HI = 11;
  localparam int unsigned       MODE_TAG_LO = 10;
  localparam int unsigned       MODE_UP_HI  = 9;

  // ------------------------------------------------------------
  // Standby polarity fields
  // ------------------------------------------------------------
  localparam int unsigned STBY_W    = 22;
  localparam int unsigned NUM_VOUT  = 13;
  localparam int unsigned NUM_SG    = 8;
  localparam int unsigned VOUT_LSB  = 0;
  localparam int unsigned SG_LSB    = 13;
  localparam int unsigned SUBCK_BIT = 21;
  localparam logic [STBY_W-1:0] STBY_RESET = 22'h000000;

  // ------------------------------------------------------------
  // Field mode fields
  // ------------------------------------------------------------
  localparam int unsigned MODE_W      = 38;
  localparam int unsigned SEL_W       = 5;
  localparam int unsigned POS_W       = 3;
  localparam int unsigned COUNT_LSB   = 35;
  localparam logic [MODE_W-1:0] MODE_RESET = 38'h00_0000_0000;
  localparam logic [POS_W-1:0]  POS_FIRST  = 3'h1;

  // ------------------------------------------------------------
  // Run and standby states on the power-state input
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SFM_RUN,
    SFM_STBY1,
    SFM_STBY2,
    SFM_STBY3
  } sfm_pwr_t;

endpackage : sfm_pkg

/* hw/sfm_serial_rx.sv */
`timescale 1ns/10ps
`default_nettype none

module sfm_serial_rx (
  input  wire logic                         ref_clk,     // System clock
  input  wire logic                         reset,       // Sync reset, active high
  input  wire logic                         ser_load_n,  // Frame select, low during frame
  input  wire logic                         ser_clk,     // Serial bit clock
  input  wire logic                         ser_data,    // Serial data, LSB first
  output logic                              wr_stb,      // One-cycle write strobe
  output logic [sfm_pkg::ADDR_W-1:0]        wr_addr,     // Received address
  output logic [sfm_pkg::DATA_W-1:0]        wr_data      // Received data
);

  logic                            sck_prev_ff;
  logic                            load_prev_ff;
  logic [sfm_pkg::FRAME_BITS-1:0]  shift_ff;
  logic [sfm_pkg::CNT_W-1:0]       cnt_ff;
  logic                            sck_rise;
  logic                            frame_end;

  assign sck_rise  = ser_clk & ~sck_prev_ff & ~ser_load_n;
  assign frame_end = ser_load_n & ~load_prev_ff;

  // ------------------------------------------------------------
  // Edge history
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sck_prev_ff  <= 1'b0;
      load_prev_ff <= 1'b1;
    end else begin
      sck_prev_ff  <= ser_clk;
      load_prev_ff <= ser_load_n;
    end
  end

  // ------------------------------------------------------------
  // Bit capture, LSB first, address then data
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_ff <= '0;
      cnt_ff   <= '0;
    end else if (frame_end) begin
      cnt_ff   <= '0;
    end else if (sck_rise) begin
      shift_ff <= {ser_data, shift_ff[sfm_pkg::FRAME_BITS-1:1]};
      if (cnt_ff != sfm_pkg::FRAME_CNT) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Frames of 40 bits or more only; short frames are dropped
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_stb  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_stb <= frame_end && (cnt_ff == sfm_pkg::FRAME_CNT);
      if (frame_end && (cnt_ff == sfm_pkg::FRAME_CNT)) begin
        wr_addr <= shift_ff[sfm_pkg::ADDR_W-1:0];
        wr_data <= shift_ff[sfm_pkg::FRAME_BITS-1:sfm_pkg::ADDR_W];
      end
    end
  end

endmodule : sfm_serial_rx

`default_nettype wire

/* sim/sfm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sfm_host_model (
  input  wire logic ref_clk,    // Clock
  output var logic  ser_load_n, // Frame select
  output var logic  ser_clk,    // Bit clock
  output var logic  ser_data    // Bit data
);
  initial begin
    ser_load_n = 1'b1;
    ser_clk    = 1'b0;
    ser_data   = 1'b0;
  end
  // Sends nb bits LSB first; bit clock idles low, data inverts when released
  task automatic send(input logic [39:0] f, input int nb);
    @(posedge ref_clk);
    ser_load_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge ref_clk);
      ser_data <= f[i];
      ser_clk  <= 1'b0;
      @(posedge ref_clk);
      ser_clk  <= 1'b1;
    end
    @(posedge ref_clk);
    ser_load_n <= 1'b1;
    ser_clk    <= 1'b0;
    ser_data   <= ~ser_data;
    repeat (3) @(posedge ref_clk);
  endtask : send
endmodule : sfm_host_model
`default_nettype wire

/* sim/sfm_regs_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module sfm_regs_chk (
  input wire logic                         ref_clk,             // Clock
  input wire logic                         reset,               // Sync reset
  input wire logic                         ser_load_n,          // Frame select
  input wire logic [1:0]                   power_state,         // Power state
  input wire logic                         output_enable_pin,   // Output enable
  input wire logic                         vertical_sync,       // Vsync
  input wire logic [sfm_pkg::NUM_VOUT-1:0] vtg_vertical,        // Run levels
  input wire logic [sfm_pkg::NUM_VOUT-1:0] vertical_out,        // Vertical outs
  input wire logic [sfm_pkg::NUM_SG-1:0]   sensor_gate_out,     // Sensor gates
  input wire logic                         substrate_clock_out, // Substrate clk
  input wire logic [sfm_pkg::STBY_W-1:0]   standby_levels,      // Polarity reg
  input wire logic [sfm_pkg::MODE_W-1:0]   mode_pending,        // Written mode
  input wire logic [sfm_pkg::MODE_W-1:0]   mode_active,         // Mode in use
  input wire logic [sfm_pkg::POS_W-1:0]    field_position,      // Position
  input wire logic [sfm_pkg::SEL_W-1:0]    field_select         // Selector
);
  logic                        vs_q_ff;
  logic                        force_lv;
  logic [2:0]                  cnt;
  logic [sfm_pkg::MODE_W-1:0]  sh;
  assign force_lv = (power_state == 2'h1) || (power_state == 2'h2) || !output_enable_pin;
  assign cnt      = mode_pending[37:35];
  assign sh       = mode_active >> (5 * (field_position - 3'h1));
  always_ff @(posedge ref_clk) begin
    vs_q_ff <= vertical_sync;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_vs_rise; vertical_sync && !vs_q_ff; endsequence
  property p_vout_forced; force_lv |=> vertical_out == $past(standby_levels[12:0]); endproperty
  a_vout_forced: assert property (p_vout_forced) else $error("vertical level wrong");
  property p_sg_forced; force_lv |=> sensor_gate_out == $past(standby_levels[20:13]); endproperty
  a_sg_forced: assert property (p_sg_forced) else $error("sensor gate level wrong");
  property p_subck_forced; force_lv |=> substrate_clock_out == $past(standby_levels[21]); endproperty
  a_subck_forced: assert property (p_subck_forced) else $error("substrate level wrong");
  property p_vout_run; !force_lv |=> vertical_out == $past(vtg_vertical); endproperty
  a_vout_run: assert property (p_vout_run) else $error("run pass-through wrong");
  property p_static;
    force_lv ##1 (force_lv && $stable(standby_levels)) |=> $stable({vertical_out, sensor_gate_out, substrate_clock_out});
  endproperty
  a_static: assert property (p_static) else $error("output toggled while forced");
  property p_hold_mode; (!vertical_sync || vs_q_ff) |=> $stable(mode_active); endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("mode changed without vsync");
  property p_load_mode; s_vs_rise |=> mode_active == $past(mode_pending); endproperty
  a_load_mode: assert property (p_load_mode) else $error("mode not loaded at vsync");
  property p_step;
    s_vs_rise ##0 (cnt != 3'h0 && field_position < cnt) |=> field_position == $past(field_position) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("position did not advance");
  property p_wrap; s_vs_rise ##0 (cnt == 3'h0 || field_position >= cnt) |=> field_position == 3'h1; endproperty
  a_wrap: assert property (p_wrap) else $error("position did not wrap");
  property p_select; field_select == sh[4:0]; endproperty
  a_select: assert property (p_select) else $error("selector wrong");
  property p_count; mode_active[37:35] != 3'h0 |-> field_position <= mode_active[37:35]; endproperty
  a_count: assert property (p_count) else $error("position beyond count");
  property p_no_write; !ser_load_n [*3] |=> $stable(mode_pending) && $stable(standby_levels); endproperty
  a_no_write: assert property (p_no_write) else $error("register changed mid frame");
endmodule : sfm_regs_chk
bind sfm_standby_mode_regs sfm_regs_chk u_chk (
  .ref_clk(ref_clk), .reset(reset), .ser_load_n(ser_load_n), .power_state(power_state),
  .output_enable_pin(output_enable_pin), .vertical_sync(vertical_sync), .vtg_vertical(vtg_vertical),
  .vertical_out(vertical_out), .sensor_gate_out(sensor_gate_out), .substrate_clock_out(substrate_clock_out),
  .standby_levels(standby_levels), .mode_pending(mode_pending), .mode_active(mode_active),
  .field_position(field_position), .field_select(field_select));
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        ref_clk, reset, ser_load_n, ser_clk, ser_data, output_enable_pin, vertical_sync;
  logic        vtg_substrate, substrate_clock_out;
  logic [1:0]  power_state;
  logic [12:0] vtg_vertical, vertical_out;
  logic [7:0]  vtg_sensor_gate, sensor_gate_out;
  logic [21:0] standby_levels, pol;
  logic [37:0] mode_pending, mode_active, mode, act;
  logic [2:0]  field_position, pos;
  logic [4:0]  field_select;
  int          bad_count, checks_done, cyc;
  sfm_standby_mode_regs dut (
    .ref_clk(ref_clk), .reset(reset), .ser_load_n(ser_load_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .power_state(power_state), .output_enable_pin(output_enable_pin), .vertical_sync(vertical_sync),
    .vtg_vertical(vtg_vertical), .vtg_sensor_gate(vtg_sensor_gate), .vtg_substrate(vtg_substrate),
    .vertical_out(vertical_out), .sensor_gate_out(sensor_gate_out), .substrate_clock_out(substrate_clock_out),
    .standby_levels(standby_levels), .mode_pending(mode_pending), .mode_active(mode_active),
    .field_position(field_position), .field_select(field_select));
  sfm_host_model host (.ref_clk(ref_clk), .ser_load_n(ser_load_n), .ser_clk(ser_clk), .ser_data(ser_data));
  function automatic logic [2:0] step(input logic [2:0] p, input logic [2:0] c);
    return (c == 3'h0 || p >= c) ? 3'h1 : p + 3'h1;
  endfunction : step
  task automatic vsync_pulse();
    @(posedge ref_clk);
    vertical_sync <= 1'b1;
    @(posedge ref_clk);
    vertical_sync <= 1'b0;
  endtask : vsync_pulse
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'h816C6513));
    {reset, power_state, output_enable_pin, vertical_sync} = {1'b1, 2'h0, 1'b1, 1'b0};
    {vtg_vertical, vtg_sensor_gate, vtg_substrate} = 22'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    `CHK({standby_levels, mode_active, field_position}, {22'h0, 38'h0, 3'h1})
    pol = 22'($urandom);
    host.send({6'h00, pol, 12'h0F3}, 40);
    `CHK(standby_levels, pol)
    host.send({2'h0, 26'h3FFFFFF, 12'h024}, 40);
    host.send({28'h0000000, 12'h0F3}, 39);
    `CHK({standby_levels, mode_pending}, {pol, 38'h0})
    // Every power state with the enable pin low and high
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      {power_state, output_enable_pin} <= 3'(k);
      {vtg_vertical, vtg_sensor_gate, vtg_substrate} <= 22'($urandom);
      @(posedge ref_clk);
      @(negedge ref_clk);
      if (power_state == 2'h1 || power_state == 2'h2 || !output_enable_pin) begin
        `CHK({vertical_out, sensor_gate_out, substrate_clock_out}, {pol[12:0], pol[20:13], pol[21]})
      end else begin
        `CHK({vertical_out, sensor_gate_out, substrate_clock_out}, {vtg_vertical, vtg_sensor_gate, vtg_substrate})
      end
    end
    // Counts zero, seven and random 1 to 6, each written and then run through nine vsync pulses
    act = 38'h0;
    pos = 3'h1;
    for (int t = 0; t < 4; t++) begin
      mode = 38'({$urandom, $urandom});
      mode[37:35] = (t == 0) ? 3'h0 : (t == 1) ? 3'h7 : 3'($urandom_range(6, 1));
      host.send({mode[27:0], 2'h2, mode[37:28]}, 40);
      `CHK({mode_pending, mode_active}, {mode, act})
      for (int v = 0; v < 9; v++) begin
        vsync_pulse();
        act = mode;
        pos = step(pos, mode[37:35]);
        @(negedge ref_clk);
        `CHK({mode_active, field_position}, {act, pos})
        `CHK(field_select, act[5 * (pos - 1) +: 5])
      end
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
